// ===== pkg/ppm_pkg.sv
// Register map, field layout and timing constants of the parallel port control block
package ppm_pkg;
   localparam int          RA_W         = 12;
   localparam int          CNT_W        = 8;
   // Register offsets
   localparam logic [11:0] OFS_OUT_STAT = 12'hf54;
   localparam logic [11:0] OFS_IN_STAT  = 12'hf55;
   localparam logic [11:0] OFS_PAD_LO   = 12'hf56;
   localparam logic [11:0] OFS_PAD_HI   = 12'hf57;
   localparam logic [11:0] OFS_WAIT     = 12'hf5c;
   localparam logic [11:0] OFS_MODE     = 12'hf5d;
   localparam logic [11:0] OFS_CTRL     = 12'hf5f;
   localparam logic [11:0] OFS_IN_BASE  = 12'hf60;
   localparam logic [11:0] OFS_OUT_BASE = 12'hf6e;
   localparam logic [11:0] OFS_OUT_LAST = 12'hf71;
   // Field positions
   localparam int BUSY_BIT  = 7;
   localparam int IRQ_LSB   = 5;
   localparam int STEP_LSB  = 3;
   localparam int WIDE_BIT  = 2;
   localparam int PMODE_LSB = 0;
   localparam int SETUP_LSB = 6;
   localparam int STRB_LSB  = 2;
   localparam int HOLD_LSB  = 0;
   localparam int ALL_BIT   = 7;
   localparam int FLAG_BIT  = 6;
   localparam int ON_BIT    = 7;
   localparam int CSF_BIT   = 6;
   localparam int CS_ABIT   = 14;
   // Mode encodings
   localparam logic [1:0] PM_LEGACY  = 2'h0;
   localparam logic [1:0] PM_ENH     = 2'h1;
   localparam logic [1:0] PM_MSTR2   = 2'h2;
   localparam logic [1:0] PM_MSTR1   = 2'h3;
   localparam logic [1:0] IRQ_NONE   = 2'h0;
   localparam logic [1:0] IRQ_EACH   = 2'h1;
   localparam logic [1:0] IRQ_STALL  = 2'h2;
   localparam logic [1:0] IRQ_FOURTH = 2'h3;
   localparam logic [1:0] STEP_NONE  = 2'h0;
   localparam logic [1:0] STEP_INC   = 2'h1;
   localparam logic [1:0] STEP_DEC   = 2'h2;
   localparam logic [1:0] STEP_BUF   = 2'h3;
   localparam logic [1:0] LAST_SLOT  = 2'h3;
   localparam logic [3:0] ALL_SLOTS  = 4'hf;
   localparam logic [3:0] SLOT0_ONLY = 4'h1;
   localparam logic [3:0] EMPTY_RST  = 4'hf;
   localparam logic [3:0] STRB_NONE  = 4'h0;
   // Timing: one instruction cycle in clock cycles
   localparam int CLK_NS  = 10;
   localparam int TCY_NS  = 10;
   localparam int TCY_CYC = (TCY_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} ppm_state_t;
endpackage

// ===== rtl/ppm_port.sv
// Parallel port mode, wait-state, pad routing and buffer status control
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Mode high bit 7 reads 1 while a master transfer runs.
// - Policy 11 interrupts on buffer 3 access or address 11 access.
// - Policy 10 stalls the processor, 01 interrupts each cycle, 00 never.
// - Step mode 11 in legacy slave walks pointers through four buffers.
// - Step 10 decrements, 01 increments address bits 15,13..0 per cycle.
// - Wide bit makes each data access two byte transfers, else one.
// - Port mode 11 is master with direction and enable strobes.
// - Port mode 10 is master with separate read and write strobes.
// - Mode 01 is addressed slave, mode 00 is slave without address.
// - Setup wait before the strobe lasts 1 to 4 instruction cycles.
// - Strobe lasts one plus 0 to 15 extra instruction cycles.
// - Data is held after the strobe for 1 to 4 instruction cycles.
// - Setup and hold settings are ignored when strobe wait is zero.
// - Top two pad enables route address 15/14 or chip select.
// - Pad enables 13 to 2 route address bits, else port I/O.
// - Low two pad enables route address bits 1 and 0.
// - Input-full summary is 1 when all writable input bytes are full.
// - External write to a full input byte sets overflow; software clears.
// - Per-buffer input-full bit is set by a write, cleared by a read.
// - Output-empty bits reset to 1, cleared by writes; summary when all readable bytes empty.
// - External read of an empty output byte sets underflow; software clears.
// - First out pair is master address in master modes, data in slave.
// - With the module off no external port access takes place.
module ppm_port (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire logic                     ce,
   input  wire logic [ppm_pkg::RA_W-1:0] reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [7:0]               reg_rdata,
   input  wire logic [7:0]               data_pins_in,
   output logic      [7:0]               data_pins_out,
   output logic                          data_pins_oe,
   input  wire logic [1:0]               addr_pins_in,
   output logic      [15:0]              addr_pins_out,
   output logic      [15:0]              pad_route_enable,
   input  wire logic                     chip_sel_pin_in,
   input  wire logic                     read_strobe_pin_in,
   input  wire logic                     write_strobe_pin_in,
   output logic                          chip_sel_pin,
   output logic                          read_strobe_pin,
   output logic                          write_strobe_pin,
   output logic                          byte_en_pin,
   output logic                          ctrl_pins_oe,
   output logic                          irq_pulse,
   output logic                          cpu_stall
);
   import ppm_pkg::*;

   logic [7:0]       in_buf [4];
   logic [7:0]       out_buf [4];
   logic [3:0]       in_full_reg, out_empty_reg, wr_mask, rd_mask;
   logic             ovf_reg, unf_reg, on_reg, csf_reg;
   logic [7:0]       pad_lo_reg, pad_hi_reg, wait_reg;
   logic [6:0]       mode_reg;
   logic [1:0]       irq_policy, addr_step_mode, pmode, wptr_reg, rptr_reg;
   logic             wide_data_select, master, in_all_full, out_all_empty;
   ppm_state_t       st_reg;
   logic [CNT_W-1:0] cnt_reg, setup_len, strobe_len, hold_len;
   logic             dir_rd_reg, byte_reg, wide_reg, busy, start, done;
   logic             sw_in_hit, sw_out_hit;
   logic [1:0]       sw_in_idx, sw_out_idx, wslot, rslot;
   logic             acc_wr, acc_rd, acc_wr_q, acc_rd_q, slv_wr_ev, slv_rd_ev;
   logic [7:0]       slv_data_reg, rd_out_reg;
   logic [14:0]      step_src, step_res;
   logic [15:0]      addr_cur;

   // Field decode
   assign irq_policy       = mode_reg[IRQ_LSB +: 2];
   assign addr_step_mode   = mode_reg[STEP_LSB +: 2];
   assign wide_data_select = mode_reg[WIDE_BIT];
   assign pmode            = mode_reg[PMODE_LSB +: 2];
   assign master = (pmode == PM_MSTR1) || (pmode == PM_MSTR2);
   assign busy   = (st_reg != ST_IDLE);

   // Software access decode
   assign sw_in_hit  = (reg_addr[RA_W-1:2] == OFS_IN_BASE[RA_W-1:2]);
   assign sw_in_idx  = reg_addr[1:0];
   assign sw_out_hit = (reg_addr >= OFS_OUT_BASE) && (reg_addr <= OFS_OUT_LAST);
   assign sw_out_idx = 2'(reg_addr - OFS_OUT_BASE);

   // Wait lengths; zero strobe wait forces every phase to one Tcy
   always_comb begin
      if (wait_reg[STRB_LSB +: 4] == STRB_NONE) begin
         setup_len = CNT_W'(TCY_CYC);
         hold_len  = CNT_W'(TCY_CYC);
      end else begin
         setup_len = CNT_W'((wait_reg[SETUP_LSB +: 2] + 3'h1) * TCY_CYC);
         hold_len  = CNT_W'((wait_reg[HOLD_LSB +: 2] + 3'h1) * TCY_CYC);
      end
      strobe_len = CNT_W'((wait_reg[STRB_LSB +: 4] + 5'h1) * TCY_CYC);
   end

   // Master start: access of the data register top byte begins a transfer
   assign start = on_reg && master && !busy && sw_in_hit
                  && (reg_wr || reg_rd)
                  && (sw_in_idx == {1'b0, wide_data_select});
   assign done  = (st_reg == ST_HOLD) && (cnt_reg == '0)
                  && !(wide_reg && !byte_reg);

   // Master transfer sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg     <= ST_IDLE;
         cnt_reg    <= '0;
         dir_rd_reg <= 1'b0;
         byte_reg   <= 1'b0;
         wide_reg   <= 1'b0;
      end else if (ce && !on_reg) begin
         st_reg <= ST_IDLE; // Switching the module off abandons a transfer
      end else if (ce) begin
         unique case (st_reg)
            ST_IDLE: begin
               if (start) begin
                  st_reg     <= ST_SETUP;
                  cnt_reg    <= setup_len - CNT_W'(1);
                  dir_rd_reg <= reg_rd;
                  byte_reg   <= 1'b0;
                  wide_reg   <= wide_data_select;
               end
            end
            ST_SETUP: begin
               if (cnt_reg == '0) begin
                  st_reg  <= ST_STROBE;
                  cnt_reg <= strobe_len - CNT_W'(1);
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            ST_STROBE: begin
               if (cnt_reg == '0) begin
                  st_reg  <= ST_HOLD;
                  cnt_reg <= hold_len - CNT_W'(1);
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            ST_HOLD: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end else if (wide_reg && !byte_reg) begin
                  st_reg   <= ST_SETUP;
                  cnt_reg  <= setup_len - CNT_W'(1);
                  byte_reg <= 1'b1;
               end else begin
                  st_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Address stepping keeps bit 14, which may be the chip select
   assign addr_cur = {out_buf[1], out_buf[0]};
   assign step_src = {addr_cur[15], addr_cur[13:0]};
   always_comb begin
      unique case (addr_step_mode)
         STEP_INC: step_res = step_src + 15'h1;
         STEP_DEC: step_res = step_src - 15'h1;
         default:  step_res = step_src;
      endcase
   end

   // Output bytes: master address in master modes, slave data otherwise
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 4; i++) out_buf[i] <= '0;
      end else if (ce) begin
         if (reg_wr && sw_out_hit) begin
            out_buf[sw_out_idx] <= reg_wdata;
         end else if (master && st_reg == ST_HOLD && cnt_reg == '0) begin
            out_buf[0] <= step_res[7:0];
            out_buf[1] <= {step_res[14], addr_cur[CS_ABIT], step_res[13:8]};
         end
      end
   end

   // Slave strobes are sampled as synchronous levels
   assign acc_wr    = on_reg && !master && chip_sel_pin_in && write_strobe_pin_in;
   assign acc_rd    = on_reg && !master && chip_sel_pin_in && read_strobe_pin_in;
   assign slv_wr_ev = acc_wr_q && !acc_wr; // Commit when the write ends
   assign slv_rd_ev = acc_rd && !acc_rd_q;
   assign wr_mask   = (pmode == PM_ENH || addr_step_mode == STEP_BUF) ? ALL_SLOTS : SLOT0_ONLY;
   assign rd_mask   = wr_mask;

   // Slot choice per slave mode
   always_comb begin
      if (pmode == PM_ENH) begin
         wslot = addr_pins_in;
         rslot = addr_pins_in;
      end else if (addr_step_mode == STEP_BUF) begin
         wslot = wptr_reg;
         rslot = rptr_reg;
      end else begin
         wslot = '0;
         rslot = '0;
      end
   end

   // Slave edge detection, capture and buffer pointers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_wr_q     <= 1'b0;
         acc_rd_q     <= 1'b0;
         slv_data_reg <= '0;
         rd_out_reg   <= '0;
         wptr_reg     <= '0;
         rptr_reg     <= '0;
      end else if (ce) begin
         acc_wr_q <= acc_wr;
         acc_rd_q <= acc_rd;
         if (acc_wr) slv_data_reg <= data_pins_in;
         if (slv_rd_ev) rd_out_reg <= out_buf[rslot];
         if (pmode != PM_LEGACY || addr_step_mode != STEP_BUF) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
         end else begin
            if (slv_wr_ev) wptr_reg <= wptr_reg + 2'h1;
            if (slv_rd_ev) rptr_reg <= rptr_reg + 2'h1;
         end
      end
   end

   // Input bytes: master read data, master software data, slave writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 4; i++) in_buf[i] <= '0;
      end else if (ce) begin
         if (st_reg == ST_STROBE && cnt_reg == '0 && dir_rd_reg)
            in_buf[{1'b0, byte_reg}] <= data_pins_in;
         else if (slv_wr_ev)
            in_buf[wslot] <= slv_data_reg; // Overflow overwrites old byte
         else if (reg_wr && sw_in_hit && master)
            in_buf[sw_in_idx] <= reg_wdata;
      end
   end

   // Buffer flags; a hardware set beats a same-cycle clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_full_reg   <= '0;
         out_empty_reg <= EMPTY_RST;
         ovf_reg       <= 1'b0;
         unf_reg       <= 1'b0;
      end else if (ce) begin
         for (int i = 0; i < 4; i++) begin
            if (slv_wr_ev && wslot == 2'(i))
               in_full_reg[i] <= 1'b1;
            else if (reg_rd && sw_in_hit && sw_in_idx == 2'(i))
               in_full_reg[i] <= 1'b0;
            if (slv_rd_ev && rslot == 2'(i))
               out_empty_reg[i] <= 1'b1;
            else if (reg_wr && sw_out_hit && sw_out_idx == 2'(i))
               out_empty_reg[i] <= 1'b0;
         end
         if (slv_wr_ev && in_full_reg[wslot])
            ovf_reg <= 1'b1;
         else if (reg_wr && reg_addr == OFS_IN_STAT)
            ovf_reg <= reg_wdata[FLAG_BIT];
         if (slv_rd_ev && out_empty_reg[rslot])
            unf_reg <= 1'b1;
         else if (reg_wr && reg_addr == OFS_OUT_STAT)
            unf_reg <= reg_wdata[FLAG_BIT];
      end
   end
   assign in_all_full   = &(in_full_reg | ~wr_mask);
   assign out_all_empty = &(out_empty_reg | ~rd_mask);

   // Configuration registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pad_lo_reg <= '0;
         pad_hi_reg <= '0;
         wait_reg   <= '0;
         mode_reg   <= '0;
         on_reg     <= 1'b0;
         csf_reg    <= 1'b0;
      end else if (ce && reg_wr) begin
         unique case (reg_addr)
            OFS_PAD_LO: pad_lo_reg <= reg_wdata;
            OFS_PAD_HI: pad_hi_reg <= reg_wdata;
            OFS_WAIT:   wait_reg   <= reg_wdata;
            OFS_MODE:   mode_reg   <= reg_wdata[6:0];
            OFS_CTRL: begin
               on_reg  <= reg_wdata[ON_BIT];
               csf_reg <= reg_wdata[CSF_BIT];
            end
            default: ;
         endcase
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            if (sw_in_hit) reg_rdata <= in_buf[sw_in_idx];
            else if (sw_out_hit) reg_rdata <= out_buf[sw_out_idx];
            else begin
               unique case (reg_addr)
                  OFS_OUT_STAT: reg_rdata <= {out_all_empty, unf_reg, 2'h0, out_empty_reg};
                  OFS_IN_STAT:  reg_rdata <= {in_all_full, ovf_reg, 2'h0, in_full_reg};
                  OFS_PAD_LO:   reg_rdata <= pad_lo_reg;
                  OFS_PAD_HI:   reg_rdata <= pad_hi_reg;
                  OFS_WAIT:     reg_rdata <= wait_reg;
                  OFS_MODE:     reg_rdata <= {busy && master, mode_reg};
                  OFS_CTRL:     reg_rdata <= {on_reg, csf_reg, 6'h0};
                  default:      reg_rdata <= '0;
               endcase
            end
         end
      end
   end

   // Interrupt pulse and stall
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_pulse <= 1'b0;
      end else if (ce) begin
         unique case (irq_policy)
            IRQ_EACH:   irq_pulse <= done || slv_wr_ev || slv_rd_ev;
            IRQ_FOURTH: irq_pulse <= (wr_mask == ALL_SLOTS) && ((slv_wr_ev && wslot == LAST_SLOT)
                                     || (slv_rd_ev && rslot == LAST_SLOT));
            default:    irq_pulse <= 1'b0;
         endcase
      end
   end
   assign cpu_stall = (irq_policy == IRQ_STALL) && busy;

   // Pin drive; master pins are decoded from sequencer flops
   assign ctrl_pins_oe  = on_reg && master;
   assign chip_sel_pin  = busy && csf_reg && addr_cur[CS_ABIT];
   assign byte_en_pin   = busy && wide_reg && byte_reg;
   always_comb begin
      if (pmode == PM_MSTR1) begin
         read_strobe_pin  = busy && dir_rd_reg;      // Direction
         write_strobe_pin = (st_reg == ST_STROBE);   // Enable
      end else begin
         read_strobe_pin  = (st_reg == ST_STROBE) && dir_rd_reg;
         write_strobe_pin = (st_reg == ST_STROBE) && !dir_rd_reg;
      end
   end
   assign data_pins_oe  = on_reg
                          && (master ? (busy && !dir_rd_reg) : (acc_rd && acc_rd_q));
   assign data_pins_out = master ? in_buf[{1'b0, byte_reg}] : rd_out_reg;
   assign pad_route_enable = {pad_hi_reg, pad_lo_reg};
   always_comb begin
      addr_pins_out = addr_cur & {pad_hi_reg, pad_lo_reg};
      if (csf_reg) addr_pins_out[CS_ABIT] = pad_hi_reg[6] && chip_sel_pin;
   end

   // Checks
   logic [CNT_W-1:0] run_cnt;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) run_cnt <= '0;
      else if (ce) run_cnt <= (st_reg == ST_STROBE) ? run_cnt + CNT_W'(1) : '0;
   end

   property p_busy_read;
      @(posedge clk) disable iff (!arst_n)
      (ce && reg_rd && reg_addr == OFS_MODE && master) |=> (reg_rdata[BUSY_BIT] == $past(busy));
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy bit mismatch");

   property p_strobe_len;
      @(posedge clk) disable iff (!arst_n)
      (ce && st_reg == ST_STROBE && cnt_reg == '0) |-> (run_cnt + CNT_W'(1) == strobe_len);
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");

   property p_short_setup;
      @(posedge clk) disable iff (!arst_n)
      (ce && start && wait_reg[STRB_LSB +: 4] == STRB_NONE) ##1 ce |=> (st_reg == ST_STROBE);
   endproperty
   a_short_setup: assert property (p_short_setup) else $error("setup not one cycle");

   property p_off_quiet;
      @(posedge clk) disable iff (!arst_n)
      !on_reg |-> (!data_pins_oe && !ctrl_pins_oe && !irq_pulse ##1 !busy);
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("pin activity while off");

   property p_overflow;
      @(posedge clk) disable iff (!arst_n)
      (ce && slv_wr_ev && in_full_reg[wslot]) |=> ovf_reg;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not flagged");

   property p_underflow;
      @(posedge clk) disable iff (!arst_n)
      (ce && slv_rd_ev && out_empty_reg[rslot]) |=> unf_reg;
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow not flagged");

   property p_in_clear;
      @(posedge clk) disable iff (!arst_n)
      (ce && reg_rd && sw_in_hit && !slv_wr_ev) |=> !in_full_reg[$past(sw_in_idx)];
   endproperty
   a_in_clear: assert property (p_in_clear) else $error("read did not clear full bit");

   property p_step_inc;
      @(posedge clk) disable iff (!arst_n)
      (ce && master && done && addr_step_mode == STEP_INC && !(reg_wr && sw_out_hit))
      |=> ({addr_cur[15], addr_cur[13:0]} == $past(step_src) + 15'h1);
   endproperty
   a_step_inc: assert property (p_step_inc) else $error("address not stepped");

   property p_stall;
      @(posedge clk) disable iff (!arst_n)
      (irq_policy == IRQ_STALL) |-> (cpu_stall == busy) && !irq_pulse ##0 1;
   endproperty
   a_stall: assert property (p_stall) else $error("stall policy broken");

   property p_wide_two;
      @(posedge clk) disable iff (!arst_n)
      (ce && st_reg == ST_HOLD && cnt_reg == '0 && wide_reg && !byte_reg)
      |=> (st_reg == ST_SETUP && byte_reg);
   endproperty
   a_wide_two: assert property (p_wide_two) else $error("second byte missing");
endmodule
`default_nettype wire

// ===== tb/ppm_partner.sv
// Far-side model: byte source for master reads and host for slave cycles
`timescale 1ns/100ps
`default_nettype none
module ppm_partner (
   input  wire logic       clk,
   input  wire logic       read_strobe_pin,
   input  wire logic [7:0] data_pins_out,
   input  wire logic       data_pins_oe,
   output logic      [7:0] data_pins_in,
   output logic      [1:0] addr_pins_in,
   output logic            chip_sel_pin_in,
   output logic            read_strobe_pin_in,
   output logic            write_strobe_pin_in
);
   localparam logic [7:0] MEM_BYTE = 8'h5a;
   logic       host_on;
   logic [7:0] host_d;
   logic [8:0] host_q;
   // Released bus shows the inverse byte outside the read strobe, so a late sample cannot pass by luck
   assign data_pins_in = host_on ? host_d : (read_strobe_pin ? MEM_BYTE : ~MEM_BYTE);
   // Quiet bus at time zero
   initial begin
      host_on = 1'b0;
      host_d = 8'h00;
      host_q = 9'h000;
      addr_pins_in = 2'h0;
      chip_sel_pin_in = 1'b0;
      read_strobe_pin_in = 1'b0;
      write_strobe_pin_in = 1'b0;
   end
   // One host strobe, then idle cycles so strobes never touch
   task automatic host_cycle(input logic [1:0] a, input logic [7:0] d, input logic wr);
      @(posedge clk);
      addr_pins_in <= a;
      host_d <= d;
      host_on <= wr;
      chip_sel_pin_in <= 1'b1;
      write_strobe_pin_in <= wr;
      read_strobe_pin_in <= !wr;
      @(posedge clk);
      if (!wr) begin
         // A read spans two cycles; the port answers in the second, enable beside data
         @(posedge clk);
         host_q <= {data_pins_oe, data_pins_out};
      end
      host_on <= 1'b0;
      chip_sel_pin_in <= 1'b0;
      write_strobe_pin_in <= 1'b0;
      read_strobe_pin_in <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_ppm_port.sv
// Self-checking bench for the parallel port control block
`timescale 1ns/100ps
`default_nettype none
module tb_ppm_port;
   import ppm_pkg::*;
   typedef struct {logic [7:0] cfg; int len; int strb;} ppm_row_t;
   ppm_row_t    rows [4] = '{'{8'h00, 3, 1}, '{8'hc3, 3, 1}, '{8'h46, 7, 2}, '{8'hff, 24, 16}};
   logic        clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, data_pins_in, d;
   logic [1:0]  addr_pins_in;
   logic [15:0] addr_pins_out, pad_route_enable;
   logic        chip_sel_pin_in, read_strobe_pin_in, write_strobe_pin_in;
   logic        read_strobe_pin, write_strobe_pin, irq_pulse, cpu_stall;
   logic [7:0]  data_pins_out;
   logic        data_pins_oe, byte_en_pin, ctrl_pins_oe;
   int          mismatches = 0, num_checks = 0, c [5], irqs = 0, k;

   ppm_port dut (.clk, .arst_n, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
                 .data_pins_in, .data_pins_out, .data_pins_oe, .addr_pins_in, .addr_pins_out,
                 .pad_route_enable, .chip_sel_pin_in, .read_strobe_pin_in, .write_strobe_pin_in,
                 .chip_sel_pin(), .read_strobe_pin, .write_strobe_pin, .byte_en_pin,
                 .ctrl_pins_oe, .irq_pulse, .cpu_stall);
   ppm_partner u (.clk, .read_strobe_pin, .data_pins_out, .data_pins_oe, .data_pins_in,
                  .addr_pins_in, .chip_sel_pin_in, .read_strobe_pin_in, .write_strobe_pin_in);

   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end
   // Interrupt pulses seen over the whole run
   always @(negedge clk) irqs += int'(irq_pulse === 1'b1);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One strobe cycle; returns just after the edge that takes it
   task automatic bus(input logic [11:0] a, input logic [7:0] wd, input logic is_rd);
      reg_addr <= a;
      reg_wdata <= wd;
      reg_rd <= is_rd;
      reg_wr <= !is_rd;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
   endtask
   // A write lets one more edge pass, so no strobe is assigned twice in one step
   task automatic wr(input logic [11:0] a, input logic [7:0] wd);
      bus(a, wd, 1'b0);
      @(posedge clk);
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [7:0] rv);
      bus(a, 8'h00, 1'b1);
      @(negedge clk) rv = reg_rdata;
      @(posedge clk);
   endtask
   // Start a master access and tally stall, strobes and interrupts over a fixed window
   task automatic run(input logic [11:0] a, input logic is_rd);
      bus(a, 8'h3c, is_rd);
      c = '{default: 0};
      repeat (40) @(negedge clk) begin
         c[0] += int'(cpu_stall === 1'b1);
         c[1] += int'(write_strobe_pin === 1'b1);
         c[2] += int'(read_strobe_pin === 1'b1);
         c[3] += int'(irq_pulse === 1'b1);
         c[4] += int'(byte_en_pin === 1'b1);
      end
      @(posedge clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Whole run needs under a thousand cycles; the limit leaves wide margin
   initial begin
      #50000;
      mismatches++;
      give_verdict;
   end
   // Main sequence: reset values, register table, master timing, slave buffers
   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      rd(OFS_OUT_STAT, d);
      chk(d, 8'h8f);
      rd(12'hf58, d);
      chk(d, 8'h00);
      wr(OFS_PAD_LO, 8'hff);
      wr(OFS_PAD_HI, 8'hff);
      rd(OFS_PAD_HI, d);
      chk(d, 8'hff);
      chk(pad_route_enable, 16'hffff);
      wr(OFS_CTRL, 8'h80);
      wr(OFS_OUT_BASE, 8'h10);
      wr(OFS_OUT_BASE + 12'h001, 8'h00);
      wr(OFS_MODE, 8'hca);
      rd(OFS_MODE, d);
      chk(d, 8'h4a);
      chk(16'(ctrl_pins_oe), 16'h0001);
      foreach (rows[i]) begin
         wr(OFS_WAIT, rows[i].cfg);
         run(OFS_IN_BASE, 1'b0);
         chk(16'(c[0]), 16'(rows[i].len));
         chk(16'(c[1]), 16'(rows[i].strb));
      end
      rd(OFS_OUT_BASE, d);
      chk(d, 8'h14);
      chk(addr_pins_out, 16'h0014);
      wr(OFS_MODE, 8'h52);
      wr(OFS_WAIT, 8'h00);
      run(OFS_IN_BASE, 1'b0);
      rd(OFS_OUT_BASE, d);
      chk(d, 8'h13);
      wr(OFS_WAIT, 8'hff);
      wr(OFS_IN_BASE, 8'h3c);
      rd(OFS_MODE, d);
      chk(d, 8'hd2);
      repeat (30) @(posedge clk);
      rd(OFS_MODE, d);
      chk(d, 8'h52);
      wr(OFS_MODE, 8'h4e);
      wr(OFS_WAIT, 8'h00);
      run(OFS_IN_BASE + 12'h001, 1'b0);
      chk(16'(c[0]), 16'h0006);
      chk(16'(c[1]), 16'h0002);
      chk(16'(c[4]), 16'h0003);
      wr(OFS_MODE, 8'h22);
      run(OFS_IN_BASE, 1'b0);
      chk(16'(c[3]), 16'h0001);
      chk(16'(c[0]), 16'h0000);
      wr(OFS_MODE, 8'h43);
      run(OFS_IN_BASE, 1'b1);
      chk(16'(c[2]), 16'h0003);
      chk(16'(c[1]), 16'h0001);
      rd(OFS_IN_BASE, d);
      chk(d, 8'h5a);
      repeat (4) @(posedge clk);
      wr(OFS_CTRL, 8'h00);
      run(OFS_IN_BASE, 1'b0);
      chk(16'(c[0] + c[1] + c[2]), 16'h0000);
      chk(16'(ctrl_pins_oe), 16'h0000);
      wr(OFS_MODE, 8'h01);
      wr(OFS_CTRL, 8'h80);
      for (int i = 0; i < 4; i++) u.host_cycle(2'(i), 8'h30, 1'b1);
      rd(OFS_IN_STAT, d);
      chk(d, 8'h8f);
      u.host_cycle(2'h0, 8'h31, 1'b1);
      rd(OFS_IN_STAT, d);
      chk(d, 8'hcf);
      rd(OFS_IN_BASE, d);
      rd(OFS_IN_STAT, d);
      chk(d, 8'h4e);
      wr(OFS_IN_STAT, 8'h00);
      rd(OFS_IN_STAT, d);
      chk(d, 8'h0e);
      u.host_cycle(2'h3, 8'h00, 1'b0);
      rd(OFS_OUT_STAT, d);
      chk(d & 8'h40, 8'h40);
      u.host_cycle(2'h0, 8'h00, 1'b0);
      chk(16'(u.host_q), 16'h0114);
      rd(OFS_OUT_STAT, d);
      chk(d, 8'h4d);
      // Buffered legacy slave: the pointer picks the slot, the fourth write interrupts
      wr(OFS_MODE, 8'h78);
      k = irqs;
      for (int i = 0; i < 4; i++) u.host_cycle(2'h0, 8'(8'h40 + i), 1'b1);
      chk(16'(irqs - k), 16'h0001);
      rd(OFS_IN_BASE + 12'h003, d);
      chk(d, 8'h43);
      give_verdict;
   end
endmodule
`default_nettype wire
